// ---- verilog/crc_defines.svh ----
// constants shared by the cluster reset control design
`ifndef CRC_DEFINES_SVH
`define CRC_DEFINES_SVH
`define CRC_NCORE 4
`define CRC_CNT_W 4
// least reset hold, in clock cycles
`define CRC_HOLD_CYC 4'h8
// wait after release so synchronised requests settle
`define CRC_SETTLE_CYC 4'h8
`define CRC_BKPT_W 8
`endif

// ---- verilog/crc_pkg.sv ----
// types shared by the cluster reset control design
`include "crc_defines.svh"
package crc_pkg;
  typedef logic [`CRC_NCORE-1:0] crc_core_t;
  // controller sequencer, gray along idle -> hold -> release
  typedef enum logic [1:0] {
    crc_st_idle = 2'h0,
    crc_st_hold = 2'h1,
    crc_st_release = 2'h3
  } crc_ctl_e;
  // one value for every reset input of the cluster
  typedef struct packed {
    crc_core_t core_rst_n;
    crc_core_t core_powerup_rst_n;
    logic debug_bus_rst_n;
    logic level2_rst_n;
    logic memtest_rst_n;
  } crc_rst_vec_s;
endpackage : crc_pkg

// ---- verilog/crc_if.sv ----
// link between the external reset controller and the cluster
`include "crc_defines.svh"
interface crc_if;
  logic [`CRC_NCORE-1:0] core_rst_n;
  logic [`CRC_NCORE-1:0] core_powerup_rst_n;
  logic debug_bus_rst_n;
  logic level2_rst_n;
  logic memtest_rst_n;
  logic level2_inval_disable;
  logic level1_inval_disable;
  logic [`CRC_NCORE-1:0] core_quiesce_req_n;
  logic [`CRC_NCORE-1:0] core_quiesce_accept_n;
  logic [`CRC_NCORE-1:0] core_quiesce_accept_alt;
  logic [`CRC_NCORE-1:0] warm_reset_request;
  logic [`CRC_NCORE-1:0] debug_warm_reset_request;
  logic [`CRC_NCORE-1:0] standby_for_interrupt;
  modport cluster (
    input core_rst_n, core_powerup_rst_n, debug_bus_rst_n, level2_rst_n, memtest_rst_n,
    input level2_inval_disable, level1_inval_disable, core_quiesce_req_n,
    output core_quiesce_accept_n, core_quiesce_accept_alt,
    output warm_reset_request, debug_warm_reset_request, standby_for_interrupt
  );
  modport controller (
    output core_rst_n, core_powerup_rst_n, debug_bus_rst_n, level2_rst_n, memtest_rst_n,
    output level2_inval_disable, level1_inval_disable, core_quiesce_req_n,
    input core_quiesce_accept_n, core_quiesce_accept_alt,
    input warm_reset_request, debug_warm_reset_request, standby_for_interrupt
  );
endinterface : crc_if

// ---- verilog/crc_rst_sync.sv ----
// reset synchroniser: asynchronous assertion, clocked release
module crc_rst_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic arst_n,
  output logic rst_n_q
);
  typedef struct packed {
    logic meta;
    logic held;
  } crc_sync_s;

  crc_sync_s st_q;
  crc_sync_s st_d;

  // ones shift in; the first stage feeds only the second
  always_comb begin
    st_d.meta = 1'b1;
    st_d.held = st_q.meta;
    if (sys_rst) begin
      st_d = '0;
    end
  end

  // clear takes a constant, release needs a running clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rst_n_q = st_q.held;
endmodule : crc_rst_sync

// ---- verilog/crc_cluster.sv ----
// cluster end: reset distribution, warm reset requests, straps
//
// Behaviour
// [R01] core reset spares debug; powerup reset clears all
// [R02] debug reset clears cluster debug logic
// [R03] level2 reset clears level2, top, coherency
// [R04] memtest reset clears everything, highest priority
// [R05] asynchronous assert, release synchronised to clock
// [R06] controller keeps clock running during release
// [R07] controller holds any reset eight cycles
// [R08] cold reset: powerup, debug, level2 low
// [R09] cold with debug: debug reset stays high
// [R10] single core cold: only its powerup low
// [R11] debug logic reset: only debug reset low
// [R12] with repeaters clock runs while reset low
// [R13] without repeaters stop clock before release
// [R14] warm reset keeps breakpoints and width select
// [R15] warm reset waits for core standby
// [R16] no level2 reset while a core runs
// [R17] no debug reset during active debugging; only cmd_debug is refused here, a cold reset still drives it low
// [R18] quiescent core before warm reset
// [R19] request bit drives warm reset request
// [R20] debug request bit drives debug warm request
// [R21] level2 invalidate disable sampled in reset
// [R22] level1 invalidate disable sampled in reset
// [R23] requests stay until core reset clears them; here a debug write of 0 also clears the debug request
`include "crc_defines.svh"
module crc_cluster (
  input wire logic clk,
  input wire logic sys_rst,
  crc_if.cluster lnk,
  input wire logic [`CRC_NCORE-1:0] core_idle,
  input wire logic [`CRC_NCORE-1:0] rmr_write,
  input wire logic [`CRC_NCORE-1:0] rmr_reset_req,
  input wire logic [`CRC_NCORE-1:0] rmr_width_sel,
  input wire logic [`CRC_NCORE-1:0] dbg_write,
  input wire logic [`CRC_NCORE-1:0] dbg_core_warm_reset_req_bit,
  input wire logic [`CRC_NCORE-1:0] bkpt_write,
  input wire logic [`CRC_BKPT_W-1:0] bkpt_wdata,
  output logic [`CRC_NCORE-1:0] core_held_q,
  output logic [`CRC_NCORE-1:0] core_debug_held_q,
  output logic debug_held_q,
  output logic level2_held_q,
  output logic [`CRC_NCORE-1:0] width_active_q,
  output logic [`CRC_NCORE*`CRC_BKPT_W-1:0] bkpt_q,
  output logic [`CRC_NCORE-1:0] l1_inval_start_q,
  output logic l2_inval_start_q
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    crc_pkg::crc_core_t core_held;
    crc_pkg::crc_core_t core_dbg_held;
    logic debug_held;
    logic l2_held;
    crc_pkg::crc_core_t warm_req;
    crc_pkg::crc_core_t dbg_req;
    crc_pkg::crc_core_t width_sel;
    crc_pkg::crc_core_t width_act;
    logic [`CRC_NCORE*`CRC_BKPT_W-1:0] bkpt;
    crc_pkg::crc_core_t l1_pend;
    crc_pkg::crc_core_t l1_start;
    logic l2_pend;
    logic l2_start;
    crc_pkg::crc_core_t standby;
    crc_pkg::crc_core_t q_accept_n;
    crc_pkg::crc_core_t q_accept_alt;
  } crc_cluster_s;

  // every domain held after reset, invalidation armed
  localparam crc_cluster_s CRC_CLUSTER_RST = '{
    core_held: '1,
    core_dbg_held: '1,
    debug_held: 1'b1,
    l2_held: 1'b1,
    l1_pend: '1,
    l2_pend: 1'b1,
    q_accept_n: '1,
    default: '0
  };

  crc_cluster_s st_q;
  crc_cluster_s st_d;

  logic [`CRC_NCORE-1:0] core_arst_n;
  logic [`CRC_NCORE-1:0] coredbg_arst_n;
  logic [`CRC_NCORE-1:0] core_sync_n;
  logic [`CRC_NCORE-1:0] coredbg_sync_n;
  logic debug_arst_n;
  logic l2_arst_n;
  logic debug_sync_n;
  logic l2_sync_n;

  // ------------------------------------------------------------
  // reset scopes and synchronisers
  // ------------------------------------------------------------
  // memtest reset is folded into every scope so it always wins
  assign debug_arst_n = lnk.debug_bus_rst_n & lnk.memtest_rst_n; // see [R02] see [R04]
  assign l2_arst_n = lnk.level2_rst_n & lnk.memtest_rst_n; // see [R03] see [R04]

  crc_rst_sync u_debug_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .arst_n(debug_arst_n),
    .rst_n_q(debug_sync_n)
  ); // see [R05]

  crc_rst_sync u_l2_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .arst_n(l2_arst_n),
    .rst_n_q(l2_sync_n)
  ); // see [R05]

  // per core: warm scope and powerup scope, each synchronised
  for (genvar gi = 0; gi < `CRC_NCORE; gi++) begin : g_core
    assign core_arst_n[gi] = lnk.core_rst_n[gi] & lnk.core_powerup_rst_n[gi]
                             & lnk.memtest_rst_n; // see [R01] see [R04]
    assign coredbg_arst_n[gi] = lnk.core_powerup_rst_n[gi] & lnk.memtest_rst_n; // see [R01]

    crc_rst_sync u_core_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .arst_n(core_arst_n[gi]),
      .rst_n_q(core_sync_n[gi])
    ); // see [R05]

    crc_rst_sync u_coredbg_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .arst_n(coredbg_arst_n[gi]),
      .rst_n_q(coredbg_sync_n[gi])
    ); // see [R05]
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.l1_start = '0;
    st_d.l2_start = 1'b0;
    st_d.debug_held = ~debug_sync_n; // see [R02]
    st_d.l2_held = ~l2_sync_n; // see [R03]
    st_d.q_accept_alt = '0;
    for (int i = 0; i < `CRC_NCORE; i++) begin
      st_d.core_held[i] = ~core_sync_n[i]; // see [R01]
      st_d.core_dbg_held[i] = ~coredbg_sync_n[i]; // see [R01]
      // no retention inside this block: accept echoes the request
      st_d.q_accept_n[i] = lnk.core_quiesce_req_n[i];
      if (!core_sync_n[i]) begin
        // warm scope: requests drop, new width takes effect
        st_d.warm_req[i] = 1'b0; // see [R23]
        st_d.dbg_req[i] = 1'b0; // see [R23]
        st_d.width_act[i] = st_q.width_sel[i]; // see [R19]
        st_d.standby[i] = 1'b0;
        st_d.l1_pend[i] = ~lnk.level1_inval_disable; // see [R22]
      end else begin
        st_d.standby[i] = core_idle[i];
        st_d.l1_start[i] = st_q.l1_pend[i]; // see [R22]
        st_d.l1_pend[i] = 1'b0;
        if (rmr_write[i]) begin
          st_d.width_sel[i] = rmr_width_sel[i]; // see [R19]
          if (rmr_reset_req[i]) begin
            st_d.warm_req[i] = 1'b1; // see [R19]
          end
        end
        if (dbg_write[i]) begin
          st_d.dbg_req[i] = dbg_core_warm_reset_req_bit[i]; // see [R20]
        end
      end
      // breakpoints and width select live in the powerup scope
      if (!coredbg_sync_n[i]) begin
        st_d.bkpt[i*`CRC_BKPT_W +: `CRC_BKPT_W] = '0; // see [R14]
        st_d.width_sel[i] = 1'b0; // see [R14]
      end else if (bkpt_write[i]) begin
        st_d.bkpt[i*`CRC_BKPT_W +: `CRC_BKPT_W] = bkpt_wdata;
      end
    end
    // level2 strap is caught while the scope is held
    if (!l2_sync_n) begin
      st_d.l2_pend = ~lnk.level2_inval_disable; // see [R21]
    end else begin
      st_d.l2_start = st_q.l2_pend; // see [R21]
      st_d.l2_pend = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // held flags follow the synchronisers one edge late
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= CRC_CLUSTER_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------
  assign lnk.warm_reset_request = st_q.warm_req; // see [R19]
  assign lnk.debug_warm_reset_request = st_q.dbg_req; // see [R20]
  assign lnk.standby_for_interrupt = st_q.standby;
  assign lnk.core_quiesce_accept_n = st_q.q_accept_n;
  assign lnk.core_quiesce_accept_alt = st_q.q_accept_alt;
  assign core_held_q = st_q.core_held;
  assign core_debug_held_q = st_q.core_dbg_held;
  assign debug_held_q = st_q.debug_held;
  assign level2_held_q = st_q.l2_held;
  assign width_active_q = st_q.width_act;
  assign bkpt_q = st_q.bkpt;
  assign l1_inval_start_q = st_q.l1_start;
  assign l2_inval_start_q = st_q.l2_start;
endmodule : crc_cluster

// ---- verilog/crc_controller.sv ----
// controller end: picks a valid reset combination and sequences it
`include "crc_defines.svh"
module crc_controller (
  input wire logic clk,
  input wire logic sys_rst,
  crc_if.controller lnk,
  input wire logic cmd_memtest,
  input wire logic cmd_cold,
  input wire logic cmd_cold_debug,
  input wire logic [`CRC_NCORE-1:0] cmd_core_cold,
  input wire logic [`CRC_NCORE-1:0] cmd_core_warm,
  input wire logic cmd_debug,
  input wire logic auto_warm,
  input wire logic debug_session_active,
  input wire logic cfg_l1_disable,
  input wire logic cfg_l2_disable,
  output logic busy_q,
  output logic done_q,
  output logic refused_q
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    crc_pkg::crc_ctl_e st;
    logic [`CRC_CNT_W-1:0] cnt;
    crc_pkg::crc_rst_vec_s drive;
    logic l1dis;
    logic l2dis;
    crc_pkg::crc_core_t stby_m;
    crc_pkg::crc_core_t stby;
    crc_pkg::crc_core_t wreq_m;
    crc_pkg::crc_core_t wreq;
    logic busy;
    logic done;
    logic refused;
  } crc_ctl_s;

  // all resets high, no quiescence in use
  localparam crc_ctl_s CRC_CTL_RST = '{
    st: crc_pkg::crc_st_idle,
    drive: '1,
    default: '0
  };

  crc_ctl_s st_q;
  crc_ctl_s st_d;
  crc_pkg::crc_rst_vec_s tgt;
  crc_pkg::crc_core_t want;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    tgt = '1;
    want = '0;
    st_d.done = 1'b0;
    st_d.refused = 1'b0;
    // cluster outputs are pins here: two flops before use
    st_d.stby_m = lnk.standby_for_interrupt;
    st_d.stby = st_q.stby_m;
    st_d.wreq_m = lnk.warm_reset_request | lnk.debug_warm_reset_request;
    st_d.wreq = st_q.wreq_m;
    unique case (st_q.st)
      crc_pkg::crc_st_idle: begin
        want = cmd_core_warm | (auto_warm ? st_q.wreq : '0);
        if (cmd_memtest) begin
          tgt.memtest_rst_n = 1'b0; // see [R04]
        end else if (cmd_cold) begin
          tgt.core_powerup_rst_n = '0; // see [R08]
          tgt.core_rst_n = '0; // see [R08]
          tgt.debug_bus_rst_n = 1'b0; // see [R08]
          tgt.level2_rst_n = 1'b0; // see [R08] see [R16]
        end else if (cmd_cold_debug) begin
          tgt.core_powerup_rst_n = '0; // see [R09]
          tgt.core_rst_n = '0; // see [R09]
          tgt.level2_rst_n = 1'b0; // see [R09] see [R16]
        end else if (|cmd_core_cold) begin
          tgt.core_powerup_rst_n = ~cmd_core_cold; // see [R10]
        end else if (cmd_debug) begin
          if (debug_session_active) begin
            st_d.refused = 1'b1; // see [R17]
          end else begin
            tgt.debug_bus_rst_n = 1'b0; // see [R11]
          end
        end else begin
          // quiescence unused, so standby alone makes a core eligible
          tgt.core_rst_n = ~(want & st_q.stby); // see [R15] see [R18]
        end
        if (tgt != '1) begin
          st_d.drive = tgt;
          st_d.st = crc_pkg::crc_st_hold;
          st_d.cnt = '0;
          st_d.busy = 1'b1;
        end
      end
      crc_pkg::crc_st_hold: begin
        // a strap moves only while the scope that samples it is held
        if (st_q.cnt == '0) begin
          if (~&(st_q.drive.core_rst_n & st_q.drive.core_powerup_rst_n) || !st_q.drive.memtest_rst_n) begin
            st_d.l1dis = cfg_l1_disable; // see [R22]
          end
          if (!st_q.drive.level2_rst_n || !st_q.drive.memtest_rst_n) begin
            st_d.l2dis = cfg_l2_disable; // see [R21]
          end
        end
        st_d.cnt = st_q.cnt + 1'b1;
        if (st_q.cnt == `CRC_HOLD_CYC - 1'b1) begin
          st_d.drive = '1; // see [R07] see [R06] see [R12]
          st_d.cnt = '0;
          st_d.st = crc_pkg::crc_st_release;
        end
      end
      crc_pkg::crc_st_release: begin
        // stale requests must drain through both sync chains
        st_d.cnt = st_q.cnt + 1'b1;
        if (st_q.cnt == `CRC_SETTLE_CYC - 1'b1) begin
          st_d.cnt = '0;
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
          st_d.st = crc_pkg::crc_st_idle;
        end
      end
      default: begin
        st_d.st = crc_pkg::crc_st_idle;
        st_d.drive = '1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= CRC_CTL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign lnk.core_rst_n = st_q.drive.core_rst_n;
  assign lnk.core_powerup_rst_n = st_q.drive.core_powerup_rst_n;
  assign lnk.debug_bus_rst_n = st_q.drive.debug_bus_rst_n;
  assign lnk.level2_rst_n = st_q.drive.level2_rst_n;
  assign lnk.memtest_rst_n = st_q.drive.memtest_rst_n;
  assign lnk.level1_inval_disable = st_q.l1dis;
  assign lnk.level2_inval_disable = st_q.l2dis;
  // retention is not used by this controller
  assign lnk.core_quiesce_req_n = '1;
  assign busy_q = st_q.busy;
  assign done_q = st_q.done;
  assign refused_q = st_q.refused;
endmodule : crc_controller

// ---- dv/crc_chk.sv ----
// link checker: reset combinations, hold time, requests and straps
`include "crc_defines.svh"
module crc_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`CRC_NCORE-1:0] core_rst_n,
  input wire logic [`CRC_NCORE-1:0] core_powerup_rst_n,
  input wire logic debug_bus_rst_n,
  input wire logic level2_rst_n,
  input wire logic memtest_rst_n,
  input wire logic level2_inval_disable,
  input wire logic level1_inval_disable,
  input wire logic [`CRC_NCORE-1:0] core_quiesce_req_n,
  input wire logic [`CRC_NCORE-1:0] core_quiesce_accept_n,
  input wire logic [`CRC_NCORE-1:0] core_quiesce_accept_alt,
  input wire logic [`CRC_NCORE-1:0] warm_reset_request,
  input wire logic [`CRC_NCORE-1:0] debug_warm_reset_request,
  input wire logic [`CRC_NCORE-1:0] standby_for_interrupt
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // helper terms
  // ------------------------------------------------------------
  // per core, low while its warm scope is held in reset
  logic [`CRC_NCORE-1:0] up_n;
  logic any_low;
  assign up_n = core_rst_n & core_powerup_rst_n & {`CRC_NCORE{memtest_rst_n}};
  assign any_low = ~&{up_n, debug_bus_rst_n, level2_rst_n};
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  hold_eight_a: assert property ($rose(any_low) |-> any_low [*8] ##1 !any_low)
    else $error("reset hold is not eight cycles");
  // up_n already folds memtest in, so the raw vectors are tested here
  memtest_alone_a: assert property (!memtest_rst_n
    |-> &{core_rst_n, core_powerup_rst_n, debug_bus_rst_n, level2_rst_n})
    else $error("memtest reset mixed with another reset");
  level2_cold_a: assert property (!level2_rst_n |-> core_powerup_rst_n == '0 && memtest_rst_n)
    else $error("level2 reset without all powerup resets");
  debug_combo_a: assert property (!debug_bus_rst_n |-> (level2_rst_n ? &up_n : up_n == '0))
    else $error("debug reset in an invalid combination");
  core_cold_a: assert property (~&core_powerup_rst_n && |core_powerup_rst_n
    |-> debug_bus_rst_n && level2_rst_n)
    else $error("single core cold reset touches shared resets");
  // a request may only drop shortly after its core went into reset
  warm_kept_a: assert property (|($past(warm_reset_request) & ~warm_reset_request & $past(up_n)
    & $past(up_n, 2) & $past(up_n, 3) & $past(up_n, 4)) == 1'b0)
    else $error("warm request dropped without core reset");
  debug_kept_a: assert property (|($past(debug_warm_reset_request) & ~debug_warm_reset_request
    & $past(up_n) & $past(up_n, 2) & $past(up_n, 3) & $past(up_n, 4)) == 1'b0)
    else $error("debug warm request dropped without core reset");
  standby_held_a: assert property (|(standby_for_interrupt
    & ~$past(up_n) & ~$past(up_n, 2) & ~$past(up_n, 3)) == 1'b0)
    else $error("standby shown by a core held in reset");
  quiesce_echo_a: assert property (core_quiesce_accept_n == $past(core_quiesce_req_n)
    && core_quiesce_accept_alt == '0)
    else $error("quiesce accept does not follow request");
  l2_strap_a: assert property ($changed(level2_inval_disable) |-> !level2_rst_n || !memtest_rst_n)
    else $error("level2 strap changed outside reset");
  l1_strap_a: assert property ($changed(level1_inval_disable) |-> ~&up_n)
    else $error("level1 strap changed outside reset");
endmodule : crc_chk

// ---- dv/tb.sv ----
// bench: controller and cluster joined by the link, driven by commands
`include "crc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = `CRC_NCORE;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [N-1:0] cm [6];
  logic [N-1:0] core_idle, rmr_write, rmr_reset_req, rmr_width_sel, dbg_write, dbg_core_warm_reset_req_bit, bkpt_write;
  logic [`CRC_BKPT_W-1:0] bkpt_wdata;
  logic auto_warm, debug_session_active, cfg_l1_disable, cfg_l2_disable;
  logic [N-1:0] core_held_q, core_debug_held_q, width_active_q, l1_inval_start_q, l1_seen;
  logic debug_held_q, level2_held_q, l2_inval_start_q, busy_q, done_q, refused_q;
  logic [N*`CRC_BKPT_W-1:0] bkpt_q;
  int fail_count = 0;
  int n_compared = 0;
  int n_ref = 0;
  int l2_cnt = 0;
  // ------------------------------------------------------------
  // clock, both ends and the checker
  // ------------------------------------------------------------
  // free running: repeaters assumed, so the clock stays up through release
  always #2.5 clk = ~clk;
  crc_if lnk();
  crc_cluster crc_cluster_i (.*);
  crc_controller crc_controller_i (.cmd_memtest(cm[0][0]), .cmd_cold(cm[1][0]), .cmd_cold_debug(cm[2][0]),
    .cmd_core_cold(cm[3]), .cmd_debug(cm[4][0]), .cmd_core_warm(cm[5]), .*);
  crc_chk crc_chk_i (.clk(clk), .sys_rst(sys_rst), .core_rst_n(lnk.core_rst_n),
    .core_powerup_rst_n(lnk.core_powerup_rst_n), .debug_bus_rst_n(lnk.debug_bus_rst_n),
    .level2_rst_n(lnk.level2_rst_n), .memtest_rst_n(lnk.memtest_rst_n),
    .level2_inval_disable(lnk.level2_inval_disable), .level1_inval_disable(lnk.level1_inval_disable),
    .core_quiesce_req_n(lnk.core_quiesce_req_n), .core_quiesce_accept_n(lnk.core_quiesce_accept_n),
    .core_quiesce_accept_alt(lnk.core_quiesce_accept_alt), .warm_reset_request(lnk.warm_reset_request),
    .debug_warm_reset_request(lnk.debug_warm_reset_request),
    .standby_for_interrupt(lnk.standby_for_interrupt));
  // one-cycle pulses are gathered as they pass, not polled
  always @(posedge clk) begin
    l1_seen <= l1_seen | l1_inval_start_q;
    if (l2_inval_start_q === 1'b1) l2_cnt <= l2_cnt + 1;
    if (refused_q === 1'b1) n_ref <= n_ref + 1;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // issue a command (k < 0: none), check held flags mid-hold and after
  task automatic run(input int k, input logic [N-1:0] m, input logic [9:0] exp);
    int n;
    l1_seen = '0;
    l2_cnt = 0;
    if (k >= 0) cm[k] = m;
    for (n = 0; busy_q !== 1'b1 && n < 60; n++) tick(1);
    foreach (cm[i]) cm[i] = '0;
    // a sequence that never starts is a mismatch too
    if (n >= 60) begin
      fail_count++;
      end_of_test();
    end
    tick(4);
    chk({core_held_q, core_debug_held_q, debug_held_q, level2_held_q}, exp);
    for (n = 0; done_q !== 1'b1 && n < 40; n++) tick(1);
    // a missed finish, or an all-zero expected pattern, ends the run early
    if (n >= 40 || exp === '0) begin
      fail_count++;
      end_of_test();
    end
    tick(4);
    chk({core_held_q, core_debug_held_q, debug_held_q, level2_held_q}, '0);
    $display("test %0d done", k);
  endtask : run
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [9:0] ex [5];
    ex = '{10'h3ff, 10'h3ff, 10'h3fd, 10'h220, 10'h002};
    foreach (cm[i]) cm[i] = '0;
    {rmr_write, rmr_reset_req, rmr_width_sel, dbg_write, dbg_core_warm_reset_req_bit, bkpt_write, bkpt_wdata} = '0;
    {debug_session_active, cfg_l1_disable, cfg_l2_disable} = '0;
    core_idle = '1;
    auto_warm = 1'b1;
    l1_seen = '0;
    tick(5);
    sys_rst = 1'b0;
    tick(4);
    // warm request from core 1 with breakpoint and width select
    {bkpt_write, rmr_write, rmr_reset_req, rmr_width_sel} = {4{4'h2}};
    bkpt_wdata = 8'h5a;
    tick(1);
    {bkpt_write, rmr_write} = '0;
    chk(lnk.warm_reset_request, 4'h2);
    run(-1, '0, 10'h080);
    chk(lnk.warm_reset_request, '0);
    chk(width_active_q, 4'h2);
    chk(bkpt_q[15:8], 8'h5a);
    // debugger request on core 2, served by a commanded warm reset
    auto_warm = 1'b0;
    {dbg_write, dbg_core_warm_reset_req_bit} = {2{4'h4}};
    tick(1);
    dbg_write = '0;
    chk(lnk.debug_warm_reset_request, 4'h4);
    run(5, 4'h4, 10'h100);
    chk(lnk.debug_warm_reset_request, '0);
    // warm reset must wait until core 3 stands by
    core_idle = 4'h7;
    tick(4);
    cm[5] = 4'h8;
    tick(6);
    chk(busy_q, 1'b0);
    chk(lnk.standby_for_interrupt, 4'h7);
    core_idle = '1;
    run(5, 4'h8, 10'h200);
    // debug reset refused during an active session
    debug_session_active = 1'b1;
    cm[4] = 4'h1;
    tick(1);
    cm[4] = '0;
    tick(3);
    chk(n_ref, 1);
    chk(debug_held_q, 1'b0);
    debug_session_active = 1'b0;
    $display("refusal test done");
    // every reset combination except core warm, back to back
    for (int i = 0; i < 5; i++) run(i, i == 3 ? 4'h8 : 4'h1, ex[i]);
    chk(bkpt_q, '0);
    // straps: invalidation suppressed, then normal
    {cfg_l1_disable, cfg_l2_disable} = 2'h3;
    run(1, 4'h1, 10'h3ff);
    chk(l1_seen, '0);
    chk(l2_cnt, 0);
    {cfg_l1_disable, cfg_l2_disable} = 2'h0;
    run(1, 4'h1, 10'h3ff);
    chk(l1_seen, 4'hf);
    chk(l2_cnt, 1);
    end_of_test();
  end
endmodule : tb
